// File: core/lpm_top.sv
// protection manager: fault latching, drive gating, fault flag, apb registers, interrupt
`timescale 1ns/1ps
`include "lpm_map.svh"

module lpm_top
    import lpm_pkg::*;
#(
    parameter int unsigned RELEASE_CYCLES = `LPM_RELEASE_CYCLES
)
(
    // clock and reset
    input  logic        ref_clk,
    input  logic        resetn,
    // apb slave
    input  logic        psel,
    input  logic        penable,
    input  logic        pwrite,
    input  logic [11:0] paddr,
    input  logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic        pready,
    output logic        pslverr,
    // comparator flags, high when the condition holds
    input  logic        temp_above_trip,
    input  logic        temp_below_release,
    input  logic        anode_above_auto,
    input  logic        anode_below_release,
    input  logic        anode_above_latch,
    input  logic        coil_above_low,
    input  logic        coil_above_high,
    input  logic        led_probe_above,
    input  logic        fb_above_trip,
    input  logic        fb_below_release,
    input  logic        fb_clamp_active,
    input  logic        supply_above_on,
    input  logic        supply_below_off,
    // supervision and switching timing
    input  logic        regulator_reset_n,
    input  logic        run_request,
    input  logic        switch_turn_on,
    // drive control
    output logic        switch_enable,
    output logic        sink_enable,
    output logic        boost_gate_hold,
    // open-drain fault flag
    output logic        fault_flag_n_o,
    output logic        fault_flag_n_oe,
    // interrupt
    output logic        irq
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    localparam logic [2:0]  BLANK_LOAD   = 3'(`LPM_BLANK_CYCLES);
    localparam logic [31:0] RELEASE_LAST = 32'(RELEASE_CYCLES);

    logic           thermal_shutdown_reg;
    logic           overvoltage_auto_stop_reg;
    logic           overvoltage_latch_stop_reg;
    logic           coil_overcurrent_reg;
    logic           led_overcurrent_reg;
    logic           feedback_overvoltage_reg;
    logic           feedback_clamp_reg;
    logic           undervoltage_lockout_reg;
    logic [2:0]     blank_count_reg;
    logic [31:0]    run_low_count_reg;
    logic           release_done;
    logic           supply_restart;
    logic           coil_hit;
    logic           run_ok;
    logic           sink_stop;
    logic           switch_stop;
    logic           switch_enable_reg;
    logic           sink_enable_reg;
    logic           fault_flag_reg;
    logic           irq_reg;
    lpm_state_t     state_reg;
    lpm_state_t     state_next;
    lpm_fault_vec_t fault_vec;
    lpm_fault_vec_t fault_prev_reg;
    lpm_fault_vec_t int_stat_reg;
    lpm_fault_vec_t int_mask_reg;
    logic [31:0]    ctrl_reg;
    logic [31:0]    status_word;
    logic [31:0]    prdata_reg;
    logic           pslverr_reg;
    logic           wr_access;
    logic           rd_setup;
    logic           addr_hit;

    ////////////////////////////////////////////////////////////////////////////
    // latch release sources

    // supply loss or regulator reset acts like a fresh power-up for the latches
    assign supply_restart = !regulator_reset_n || undervoltage_lockout_reg;

    // run_request low time, saturating so a long hold keeps the release active
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            run_low_count_reg <= 32'h0000_0000;
        else if (run_request)
            run_low_count_reg <= 32'h0000_0000;
        else if (run_low_count_reg != RELEASE_LAST)
            run_low_count_reg <= run_low_count_reg + 32'h0000_0001;
    end

    assign release_done = (run_low_count_reg == RELEASE_LAST);

    ////////////////////////////////////////////////////////////////////////////
    // automatic faults, with hysteresis except the clamp

    // thermal: trip flag sets, release flag clears; set wins if both appear
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            thermal_shutdown_reg <= 1'b0;
        else if (temp_above_trip)
            thermal_shutdown_reg <= 1'b1;
        else if (temp_below_release)
            thermal_shutdown_reg <= 1'b0;
    end

    // anode first overvoltage level, self-releasing
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            overvoltage_auto_stop_reg <= 1'b0;
        else if (anode_above_auto)
            overvoltage_auto_stop_reg <= 1'b1;
        else if (anode_below_release)
            overvoltage_auto_stop_reg <= 1'b0;
    end

    // comparator threshold follows feedback_reference, so the flags carry it
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            feedback_overvoltage_reg <= 1'b0;
        else if (fb_above_trip)
            feedback_overvoltage_reg <= 1'b1;
        else if (fb_below_release)
            feedback_overvoltage_reg <= 1'b0;
    end

    // clamp is reported while present and takes no latch
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            feedback_clamp_reg <= 1'b0;
        else
            feedback_clamp_reg <= fb_clamp_active;
    end

    // lockout starts active: nothing switches until the supply has risen
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            undervoltage_lockout_reg <= 1'b1;
        else if (supply_below_off)
            undervoltage_lockout_reg <= 1'b1;
        else if (supply_above_on)
            undervoltage_lockout_reg <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // latched faults

    // high overvoltage: only release or restart clears, never the monitor level
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            overvoltage_latch_stop_reg <= 1'b0;
        else if (anode_above_latch)
            overvoltage_latch_stop_reg <= 1'b1;
        else if (release_done || supply_restart)
            overvoltage_latch_stop_reg <= 1'b0;
    end

    // blanking window reloads on each turn-on; a new turn-on restarts it
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            blank_count_reg <= 3'h0;
        else if (switch_turn_on)
            blank_count_reg <= BLANK_LOAD;
        else if (blank_count_reg != 3'h0)
            blank_count_reg <= blank_count_reg - 3'h1;
    end

    // threshold choice is software's since the two published levels disagree;
    // an open pin is pulled past either level and trips like a real fault
    assign coil_hit = (ctrl_reg[`LPM_CTRL_COIL_SEL] ? coil_above_high : coil_above_low)
                    && (blank_count_reg == 3'h0) && !switch_turn_on;

    // coil overcurrent latches; a low cycle of run_request clears it unless coil_hit is set, since set wins
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            coil_overcurrent_reg <= 1'b0;
        else if (coil_hit)
            coil_overcurrent_reg <= 1'b1;
        else if (!run_request || supply_restart)
            coil_overcurrent_reg <= 1'b0;
    end

    // led overcurrent latches; floating probe input reads high and trips
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            led_overcurrent_reg <= 1'b0;
        else if (led_probe_above)
            led_overcurrent_reg <= 1'b1;
        else if (release_done || supply_restart)
            led_overcurrent_reg <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // drive gating

    always_comb
    begin
        fault_vec                    = '0;
        fault_vec[`LPM_F_THERMAL]    = thermal_shutdown_reg;
        fault_vec[`LPM_F_OV_AUTO]    = overvoltage_auto_stop_reg;
        fault_vec[`LPM_F_OV_LATCH]   = overvoltage_latch_stop_reg;
        fault_vec[`LPM_F_COIL_OC]    = coil_overcurrent_reg;
        fault_vec[`LPM_F_LED_OC]     = led_overcurrent_reg;
        fault_vec[`LPM_F_FB_OV]      = feedback_overvoltage_reg;
        fault_vec[`LPM_F_FB_CLAMP]   = feedback_clamp_reg;
        fault_vec[`LPM_F_UNDERVOLTAGE_LOCKOUT]       = undervoltage_lockout_reg;
    end

    // start needs lockout released, regulator out of reset and a run request
    assign run_ok      = !undervoltage_lockout_reg && regulator_reset_n && run_request;
    assign switch_stop = |fault_vec;
    // feedback overvoltage leaves the current sink running
    assign sink_stop   = |(fault_vec & ~(lpm_fault_vec_t'(1) << `LPM_F_FB_OV));

    // enables are registered so glitches on the flags never reach the gates
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            switch_enable_reg <= 1'b0;
            sink_enable_reg   <= 1'b0;
        end
        else
        begin
            switch_enable_reg <= run_ok && !switch_stop;
            sink_enable_reg   <= run_ok && !sink_stop;
        end
    end

    assign switch_enable   = switch_enable_reg;
    assign sink_enable     = sink_enable_reg;
    // boost gate parked high so a shorted high-side switch opens the fuse
    assign boost_gate_hold = overvoltage_latch_stop_reg;

    ////////////////////////////////////////////////////////////////////////////
    // operating state for status

    always_comb
    begin
        case (state_reg)
            LPM_ST_LOCKOUT,
            LPM_ST_IDLE,
            LPM_ST_FAULT,
            LPM_ST_RUN:
            begin
                if (undervoltage_lockout_reg || !regulator_reset_n)
                    state_next = LPM_ST_LOCKOUT;
                else if (!run_request)
                    state_next = LPM_ST_IDLE;
                else if (switch_stop)
                    state_next = LPM_ST_FAULT;
                else
                    state_next = LPM_ST_RUN;
            end
            default:
                state_next = LPM_ST_LOCKOUT;
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            state_reg <= LPM_ST_LOCKOUT;
        else
            state_reg <= state_next;
    end

    ////////////////////////////////////////////////////////////////////////////
    // fault flag

    // any active protection pulls the flag low; the pull-up lives outside
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            fault_flag_reg <= 1'b0;
        else
            fault_flag_reg <= |fault_vec;
    end

    assign fault_flag_n_o  = 1'b0;
    assign fault_flag_n_oe = fault_flag_reg;

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status

    assign wr_access = psel && penable && pwrite;

    // lockout is live out of reset, so its history starts set: reset is no onset
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            fault_prev_reg <= lpm_fault_vec_t'(1) << `LPM_F_UNDERVOLTAGE_LOCKOUT;
        else
            fault_prev_reg <= fault_vec;
    end

    // per fault: onset sets the sticky bit, write-one clears, set wins
    generate
        for (genvar i = 0; i < `LPM_NUM_FAULTS; i++)
        begin : g_sticky
            always_ff @(posedge ref_clk or negedge resetn)
            begin
                if (!resetn)
                    int_stat_reg[i] <= 1'b0;
                else if (fault_vec[i] && !fault_prev_reg[i])
                    int_stat_reg[i] <= 1'b1;
                else if (wr_access && (paddr == `LPM_INT_STAT_OFS) && pwdata[i])
                    int_stat_reg[i] <= 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            irq_reg <= 1'b0;
        else
            irq_reg <= |(int_stat_reg & int_mask_reg);
    end

    assign irq = irq_reg;

    ////////////////////////////////////////////////////////////////////////////
    // apb registers

    // writes land at the access-phase edge
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_reg     <= `LPM_CTRL_RESET;
            int_mask_reg <= `LPM_MASK_RESET;
        end
        else if (wr_access)
        begin
            if (paddr == `LPM_CTRL_OFS)
                ctrl_reg <= {31'h0, pwdata[`LPM_CTRL_COIL_SEL]};
            if (paddr == `LPM_INT_MASK_OFS)
                int_mask_reg <= pwdata[7:0];
        end
    end

    always_comb
    begin
        status_word                         = 32'h0000_0000;
        status_word[7:0]                    = fault_vec;
        status_word[`LPM_STAT_STATE_LSB+:2] = state_reg;
        status_word[`LPM_STAT_SW_EN]        = switch_enable_reg;
        status_word[`LPM_STAT_SINK_EN]      = sink_enable_reg;
        status_word[`LPM_STAT_RUN_REQ]      = run_request;
    end

    assign addr_hit = (paddr == `LPM_CTRL_OFS) || (paddr == `LPM_STATUS_OFS)
                   || (paddr == `LPM_INT_STAT_OFS) || (paddr == `LPM_INT_MASK_OFS);
    assign rd_setup = psel && !penable;

    // read data and error are captured in setup so they come from flip-flops
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end
        else if (rd_setup)
        begin
            pslverr_reg <= !addr_hit;
            case (paddr)
                `LPM_CTRL_OFS:     prdata_reg <= ctrl_reg;
                `LPM_STATUS_OFS:   prdata_reg <= status_word;
                `LPM_INT_STAT_OFS: prdata_reg <= {24'h0, int_stat_reg};
                `LPM_INT_MASK_OFS: prdata_reg <= {24'h0, int_mask_reg};
                default:           prdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    // zero wait states: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign prdata  = prdata_reg;
    assign pslverr = pslverr_reg && psel && penable;

endmodule

// File: core/lpm_map.svh
// offsets, field positions, reset values and timing counts of the protection manager
`ifndef LPM_MAP_SVH
`define LPM_MAP_SVH

// clock and timing
`define LPM_CLK_PERIOD_NS   100
`define LPM_CLK_HZ          10000000
`define LPM_BLANK_NS        350
`define LPM_BLANK_CYCLES    ((`LPM_BLANK_NS + `LPM_CLK_PERIOD_NS - 1) / `LPM_CLK_PERIOD_NS)
`define LPM_RELEASE_MS      10
`define LPM_RELEASE_CYCLES  (`LPM_RELEASE_MS * (`LPM_CLK_HZ / 1000))

// register byte offsets
`define LPM_CTRL_OFS        12'h000
`define LPM_STATUS_OFS      12'h004
`define LPM_INT_STAT_OFS    12'h008
`define LPM_INT_MASK_OFS    12'h00c

// control register fields
`define LPM_CTRL_COIL_SEL   0
`define LPM_CTRL_RESET      32'h0000_0000

// fault bit positions (status, interrupt status and mask share them)
`define LPM_NUM_FAULTS      8
`define LPM_F_THERMAL       0
`define LPM_F_OV_AUTO       1
`define LPM_F_OV_LATCH      2
`define LPM_F_COIL_OC       3
`define LPM_F_LED_OC        4
`define LPM_F_FB_OV         5
`define LPM_F_FB_CLAMP      6
`define LPM_F_UNDERVOLTAGE_LOCKOUT          7

// status register extra fields
`define LPM_STAT_STATE_LSB  8
`define LPM_STAT_SW_EN      10
`define LPM_STAT_SINK_EN    11
`define LPM_STAT_RUN_REQ    12

`define LPM_MASK_RESET      8'h00

`endif

// File: core/lpm_pkg.sv
// types shared by the protection manager
package lpm_pkg;

    typedef logic [7:0] lpm_fault_vec_t;

    // overall operating state, reported in the status register
    typedef enum logic [1:0] {
        LPM_ST_LOCKOUT = 2'b00,
        LPM_ST_IDLE    = 2'b01,
        LPM_ST_FAULT   = 2'b10,
        LPM_ST_RUN     = 2'b11
    } lpm_state_t;

endpackage

// File: tb/lpm_assertions.sv
// concurrent checks on the protection manager ports
`timescale 1ns/1ps
module lpm_assertions #(
    parameter int unsigned RELEASE_CYCLES = 20
)
(
    // clock and reset
    input logic ref_clk,
    input logic resetn,
    // comparator flags and supervision
    input logic temp_above_trip,
    input logic anode_above_auto,
    input logic anode_above_latch,
    input logic fb_above_trip,
    input logic supply_above_on,
    input logic supply_below_off,
    input logic regulator_reset_n,
    input logic run_request,
    // drive control and flag
    input logic switch_enable,
    input logic sink_enable,
    input logic boost_gate_hold,
    input logic fault_flag_n_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    int unsigned low_cnt;

    ////////////////////////////////////////////////////////////////////////////////
    // run-low streak; a fresh high overvoltage restarts it, since set wins over clear
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            low_cnt <= 0;
        else if (run_request || anode_above_latch)
            low_cnt <= 0;
        else if (low_cnt < RELEASE_CYCLES + 8)
            low_cnt <= low_cnt + 1;
    end

    sequence s_latch_stop;
        boost_gate_hold ##1 (!switch_enable && !sink_enable && fault_flag_n_oe);
    endsequence

    sequence s_supply_up;
        (supply_above_on && regulator_reset_n)[*2];
    endsequence

    ////////////////////////////////////////////////////////////////////////////////
    a_latch_walk: assert property (anode_above_latch |-> ##1 s_latch_stop)
        else $error("high overvoltage did not latch the stop");
    a_latch_holds: assert property (
        s_supply_up ##0 (boost_gate_hold && low_cnt + 1 < RELEASE_CYCLES) |=> boost_gate_hold)
        else $error("overvoltage latch cleared early");
    a_latch_release: assert property (low_cnt == RELEASE_CYCLES + 2 |-> !boost_gate_hold)
        else $error("overvoltage latch not cleared by long run low");
    a_temp_stop: assert property (temp_above_trip |-> ##2 (!switch_enable && !sink_enable))
        else $error("thermal trip did not stop both drives");
    a_anode_stop: assert property (anode_above_auto |->
        ##2 (!switch_enable && !sink_enable && fault_flag_n_oe))
        else $error("anode overvoltage did not stop both drives");
    a_fb_switch_only: assert property (fb_above_trip |-> ##2 !switch_enable)
        else $error("feedback overvoltage did not stop switching");
    a_lockout_stop: assert property (supply_below_off |-> ##2 !switch_enable)
        else $error("low supply did not stop switching");
    a_run_gate: assert property (!run_request[*2] |-> ##1 (!switch_enable && !sink_enable))
        else $error("drives enabled without run request");
    a_flag_switch: assert property (switch_enable |-> !fault_flag_n_oe)
        else $error("switching while fault flag pulled low");
endmodule

// File: tb/lpm_far_side.sv
// comparator front end seen by the protection manager, with sense-pin pull-ups
`timescale 1ns/1ps
module lpm_far_side (
    // thermal and anode comparators
    output logic temp_above_trip,
    output logic temp_below_release,
    output logic anode_above_auto,
    output logic anode_below_release,
    output logic anode_above_latch,
    // current sense comparators
    output logic coil_above_low,
    output logic coil_above_high,
    output logic led_probe_above,
    // feedback and supply comparators
    output logic fb_above_trip,
    output logic fb_below_release,
    output logic fb_clamp_active,
    output logic supply_above_on,
    output logic supply_below_off
);
    // 0 temp C, 1 anode mV, 2 coil mV, 3 led mV, 4 fb mV, 5 ref mV, 6 supply mV, 7/8 open
    int lvl [9] = '{25, 2000, 0, 200, 3000, 2300, 15000, 0, 0};

    // called just after a rising edge, so levels move off the sampling edge
    task automatic set(input int idx, input int val);
        lvl[idx] <= val;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // trip points; an open sense pin is pulled far above its threshold
    assign temp_above_trip     = lvl[0] >= 150;
    assign temp_below_release  = lvl[0] <= 95;
    assign anode_above_auto    = lvl[1] >= 3050;
    assign anode_below_release = lvl[1] <= 2950;
    assign anode_above_latch   = lvl[1] >= 3300;
    assign coil_above_low      = lvl[7] != 0 || lvl[2] >= 1200;
    assign coil_above_high     = lvl[7] != 0 || lvl[2] >= 1500;
    assign led_probe_above     = lvl[8] != 0 || lvl[3] >= 500;
    // feedback trip scales with the reference level
    assign fb_above_trip       = lvl[4] * 230 >= 465 * lvl[5];
    assign fb_below_release    = lvl[4] * 230 <= 455 * lvl[5];
    assign fb_clamp_active     = lvl[4] >= 8000;
    assign supply_above_on     = lvl[6] >= 12200;
    assign supply_below_off    = lvl[6] <= 8500;
endmodule

// File: tb/tb_led_driver_protection_manager.sv
// self-checking bench for the protection manager
`timescale 1ns/1ps
module tb_led_driver_protection_manager;
    localparam int REL = 20;
    logic        ref_clk, resetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        temp_above_trip, temp_below_release, anode_above_auto, anode_below_release;
    logic        anode_above_latch, coil_above_low, coil_above_high, led_probe_above;
    logic        fb_above_trip, fb_below_release, fb_clamp_active;
    logic        supply_above_on, supply_below_off;
    logic        regulator_reset_n, run_request, switch_turn_on;
    logic        switch_enable, sink_enable, boost_gate_hold, fault_flag_n_o, fault_flag_n_oe, irq;
    wire         fault_flag_n = fault_flag_n_oe ? fault_flag_n_o : 1'b1; // external pull-up
    int          failures, checks_done, cyc;

    lpm_top #(.RELEASE_CYCLES(REL)) dut (.ref_clk, .resetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .temp_above_trip, .temp_below_release,
        .anode_above_auto, .anode_below_release, .anode_above_latch, .coil_above_low,
        .coil_above_high, .led_probe_above, .fb_above_trip, .fb_below_release, .fb_clamp_active,
        .supply_above_on, .supply_below_off, .regulator_reset_n, .run_request, .switch_turn_on,
        .switch_enable, .sink_enable, .boost_gate_hold, .fault_flag_n_o, .fault_flag_n_oe, .irq);

    lpm_far_side far (.temp_above_trip, .temp_below_release, .anode_above_auto,
        .anode_below_release, .anode_above_latch, .coil_above_low, .coil_above_high,
        .led_probe_above, .fb_above_trip, .fb_below_release, .fb_clamp_active,
        .supply_above_on, .supply_below_off);

    ////////////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial
    begin
        ref_clk = 0;
        forever #50 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD t=%0t got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // one apb transfer; values are taken in the active region, before the edge lands
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // move one analog level, let the two-edge path settle, compare {switch, sink, flag}
    task automatic step(input int idx, input int val, input logic [2:0] e);
        @(posedge ref_clk);
        far.set(idx, val);
        repeat (4) @(posedge ref_clk);
        chk({29'h0, switch_enable, sink_enable, fault_flag_n}, {29'h0, e});
    endtask

    task automatic run_low(input int n);
        @(posedge ref_clk);
        run_request <= 1'b0;
        repeat (n) @(posedge ref_clk);
        run_request <= 1'b1;
        repeat (4) @(posedge ref_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, switch_turn_on} = '0;
        resetn = 0;
        run_request = 1;
        regulator_reset_n = 1;
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        step(6, 15000, 3'b111);
        chk({31'h0, pready}, 32'h1);
        apb(0, 12'h000, 0);
        chk(rd, 32'h0);
        apb(0, 12'h00c, 0);
        chk(rd, 32'h0);
        apb(0, 12'h010, 0);
        chk({err, rd[30:0]}, 32'h8000_0000);
        apb(0, 12'h008, 0);
        chk(rd, 32'h0);
        apb(1, 12'h008, 32'hff);
        apb(0, 12'h008, 0);
        chk({rd[31:1], irq}, 32'h0);
        // thermal trip with hysteresis, unmasked interrupt
        apb(1, 12'h00c, 32'h01);
        step(0, 160, 3'b000);
        chk({31'h0, irq}, 32'h1);
        apb(0, 12'h004, 0);
        chk(rd, 32'h1201);
        apb(1, 12'h008, 32'h01);
        step(0, 120, 3'b000);
        chk({31'h0, irq}, 32'h0);
        step(0, 90, 3'b111);
        // anode auto stop, masked then unmasked
        apb(1, 12'h00c, 32'h00);
        step(1, 3100, 3'b000);
        apb(0, 12'h008, 0);
        chk({rd[31:1], irq}, 32'h2);
        apb(1, 12'h00c, 32'h02);
        repeat (2) @(posedge ref_clk);
        chk({31'h0, irq}, 32'h1);
        apb(1, 12'h008, 32'h02);
        step(1, 3000, 3'b000);
        chk({31'h0, irq}, 32'h0);
        step(1, 2900, 3'b111);
        // feedback stop keeps the sink; trip follows the reference
        step(4, 4700, 3'b010);
        step(4, 4600, 3'b010);
        step(4, 4500, 3'b111);
        step(5, 4000, 3'b111);
        step(4, 4700, 3'b111);
        step(5, 2300, 3'b010);
        step(4, 8100, 3'b000);
        apb(0, 12'h004, 0);
        chk(rd & 32'hff, 32'h60);
        step(4, 3000, 3'b111);
        // supply lockout hysteresis
        step(6, 10000, 3'b111);
        step(6, 8000, 3'b000);
        step(6, 10000, 3'b000);
        step(6, 13000, 3'b111);
        // latched overvoltage: short run-low is not enough
        step(1, 3400, 3'b000);
        chk({31'h0, boost_gate_hold}, 32'h1);
        step(1, 2000, 3'b000);
        run_low(REL - 3);
        chk({29'h0, switch_enable, sink_enable, boost_gate_hold}, 32'h1);
        run_low(REL + 3);
        chk({29'h0, switch_enable, sink_enable, fault_flag_n}, 32'h7);
        // led overcurrent latch, open probe cleared by regulator restart
        step(3, 600, 3'b000);
        step(3, 200, 3'b000);
        run_low(REL + 3);
        step(8, 1, 3'b000);
        step(8, 0, 3'b000);
        @(posedge ref_clk);
        regulator_reset_n <= 1'b0;
        @(posedge ref_clk);
        regulator_reset_n <= 1'b1;
        step(3, 200, 3'b111);
        // coil flag inside the blanking window is ignored
        @(posedge ref_clk);
        switch_turn_on <= 1'b1;
        far.set(2, 1300);
        @(posedge ref_clk);
        switch_turn_on <= 1'b0;
        repeat (3) @(posedge ref_clk);
        step(2, 0, 3'b111);
        step(2, 1300, 3'b000);
        step(2, 0, 3'b000);
        run_low(2);
        step(2, 0, 3'b111);
        // upper coil threshold selected
        apb(1, 12'h000, 32'h1);
        step(2, 1300, 3'b111);
        step(2, 1600, 3'b000);
        step(2, 0, 3'b000);
        step(7, 1, 3'b000);
        step(7, 0, 3'b000);
        run_low(2);
        step(2, 0, 3'b111);
        end_of_test();
    end
endmodule

bind lpm_top lpm_assertions #(.RELEASE_CYCLES(RELEASE_CYCLES)) chk_i (.ref_clk, .resetn,
    .temp_above_trip, .anode_above_auto, .anode_above_latch, .fb_above_trip, .supply_above_on,
    .supply_below_off, .regulator_reset_n, .run_request, .switch_enable, .sink_enable,
    .boost_gate_hold, .fault_flag_n_oe);
